// ---- common/lfcs_pkg.sv ----
// package: lock and fuse layout, reset values, pointers, modes and commands
package lfcs_pkg;
    // lock byte fields; bits 7:2 always read 1
    localparam int unsigned LOCK_ONE_BIT     = 0;
    localparam int unsigned LOCK_TWO_BIT     = 1;
    localparam logic [5:0]  LOCK_PAD         = 6'h3F;
    localparam logic [1:0]  LOCK_RESET       = 2'h3;
    // high fuse byte fields
    localparam int unsigned FH_SELF_PROG_BIT = 4;
    localparam int unsigned FH_DEBUG_BIT     = 3;
    localparam int unsigned FH_BOD_LSB       = 1;
    localparam int unsigned FH_RST_DIS_BIT   = 0;
    localparam logic [7:0]  FH_RESET         = 8'hFF;
    // low fuse byte fields
    localparam int unsigned FL_SERIAL_BIT    = 7;
    localparam int unsigned FL_EE_KEEP_BIT   = 6;
    localparam int unsigned FL_WDT_ON_BIT    = 5;
    localparam int unsigned FL_DIV8_BIT      = 4;
    localparam int unsigned FL_SUT_LSB       = 2;
    localparam int unsigned FL_CLOCK_SOURCE_SELECT_LSB     = 0;
    localparam logic [7:0]  FL_RESET         = 8'h6A;
    // firmware load pointers and read window
    localparam logic [15:0] PTR_FUSE_LOW     = 16'h0000;
    localparam logic [15:0] PTR_LOCK         = 16'h0001;
    localparam logic [15:0] PTR_FUSE_HIGH    = 16'h0003;
    localparam logic [1:0]  FW_WINDOW_CYCLES = 2'h3;
    // signature area addresses
    localparam logic [7:0]  SIG_ADDR_0       = 8'h00;
    localparam logic [7:0]  SIG_ADDR_1       = 8'h01;
    localparam logic [7:0]  SIG_ADDR_2       = 8'h02;
    localparam logic [7:0]  CAL_ADDR_FAST    = 8'h00;
    localparam logic [7:0]  CAL_ADDR_SLOW    = 8'h01;
    localparam logic [7:0]  READ_BLANK       = 8'hFF;

    typedef enum logic [1:0] {
        LFCS_MODE_OPEN,
        LFCS_MODE_WRITE_LOCK,
        LFCS_MODE_FULL_LOCK
    } lfcs_mode_t;

    typedef enum logic [3:0] {
        LFCS_OP_NOP,
        LFCS_OP_WR_FUSE_LOW,
        LFCS_OP_WR_FUSE_HIGH,
        LFCS_OP_WR_LOCK,
        LFCS_OP_CHIP_ERASE,
        LFCS_OP_RD_CONFIG,
        LFCS_OP_RD_SIGNATURE,
        LFCS_OP_RD_CALIB,
        LFCS_OP_MEM_WRITE,
        LFCS_OP_MEM_VERIFY
    } lfcs_op_t;

    // pointer decode shared by programmer and firmware reads
    function automatic logic [7:0] lfcs_sel_config(input logic [15:0] ptr, input logic [7:0] low,
                                                   input logic [1:0] lock, input logic [7:0] high);
        logic [7:0] r;
        r = READ_BLANK;
        if (ptr == PTR_FUSE_LOW)
            r = low;
        else if (ptr == PTR_LOCK)
            r = {LOCK_PAD, lock};
        else if (ptr == PTR_FUSE_HIGH)
            r = high;
        return r;
    endfunction : lfcs_sel_config
endpackage : lfcs_pkg

// ---- verilog/lfcs_lock_decode.sv ----
// lock bit pair to protection mode decoder
`timescale 1ns/1ps
`default_nettype none
module lfcs_lock_decode
    import lfcs_pkg::*;
(
    // stored lock pair, 0 means programmed
    input  wire logic [1:0]          i_lock,
    // decoded protection
    output lfcs_pkg::lfcs_mode_t     o_mode,
    output logic                     o_fuse_locked
);
    // the undefined pattern falls to the strongest protection
    assign o_mode = (i_lock == 2'h3) ? LFCS_MODE_OPEN :
                    (i_lock == 2'h2) ? LFCS_MODE_WRITE_LOCK : LFCS_MODE_FULL_LOCK;
    assign o_fuse_locked = (i_lock != 2'h3);
endmodule : lfcs_lock_decode
`default_nettype wire

// ---- verilog/lfcs_read_window.sv ----
// short window during which a firmware load returns configuration bytes
`timescale 1ns/1ps
`default_nettype none
module lfcs_read_window
    import lfcs_pkg::*;
#(
    parameter logic [1:0] WINDOW = FW_WINDOW_CYCLES
) (
    // clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst_b,
    // arm and use
    input  wire logic i_arm,
    input  wire logic i_load,
    // window state
    output logic      o_fire,
    output logic      o_open
);
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;

    // window closes on use or after the last cycle; re-arming restarts it
    assign o_open = (cnt_q != 2'h0);
    assign o_fire = o_open & i_load;
    assign cnt_d  = i_arm ? WINDOW : (o_fire ? 2'h0 : (o_open ? cnt_q - 2'h1 : 2'h0));

    // window counter
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            cnt_q <= 2'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule : lfcs_read_window
`default_nettype wire

// ---- verilog/lfcs_top.sv ----
// lock bit and configuration fuse store with calibration and signature reads
`timescale 1ns/1ps
`default_nettype none
module lfcs_top
    import lfcs_pkg::*;
#(
    parameter logic [7:0] SIG_BYTE_0 = 8'h5A,  // arbitrary identity value
    parameter logic [7:0] SIG_BYTE_1 = 8'h3C,  // arbitrary identity value
    parameter logic [7:0] SIG_BYTE_2 = 8'h01,  // arbitrary identity value
    parameter logic [7:0] CAL_FAST   = 8'h80,
    parameter logic [7:0] CAL_SLOW   = 8'h80
) (
    // clock and reset
    input  wire logic                i_clock,
    input  wire logic                i_rst_b,
    input  wire logic                i_power_on,
    // programmer side
    input  wire logic                i_prog_mode,
    input  wire logic                i_prog_serial,
    input  wire logic                i_cmd_valid,
    input  wire lfcs_pkg::lfcs_op_t  i_cmd_op,
    input  wire logic [7:0]          i_cmd_addr,
    input  wire logic [7:0]          i_cmd_data,
    output logic                     o_ans_valid,
    output logic [7:0]               o_ans_data,
    output logic                     o_cmd_refused,
    output logic                     o_mem_write_grant,
    output logic                     o_mem_verify_grant,
    output logic                     o_flash_erase,
    output logic                     o_eeprom_erase,
    // firmware side
    input  wire logic                i_fw_ctrl_we,
    input  wire logic                i_fw_read_config_bits_enable,
    input  wire logic                i_fw_self_program_enable,
    input  wire logic                i_fw_load,
    input  wire logic [15:0]         i_fw_ptr,
    input  wire logic                i_oscillator_calibration_register_we,
    input  wire logic [7:0]          i_oscillator_calibration_register_wdata,
    output logic                     o_fw_valid,
    output logic [7:0]               o_fw_data,
    output logic [7:0]               o_oscillator_calibration_register,
    // configuration to the rest of the chip; lock mode and eeprom preserve follow the store, not the latch
    output logic [7:0]               o_config_low_byte,
    output logic [7:0]               o_config_high_byte,
    output lfcs_pkg::lfcs_mode_t     o_protect_mode,
    output logic                     o_debug_link_en,
    output logic                     o_debug_pm_read_en,
    output logic                     o_eeprom_preserve,
    output logic                     o_watchdog_forced_on,
    output logic                     o_watchdog_irq_allowed
);
    // nonvolatile copies and working state
    logic [1:0]  lock_q;
    logic [7:0]  nv_low_q;
    logic [7:0]  nv_high_q;
    logic        prog_mode_q;
    lfcs_mode_t  mode;
    logic        fuse_locked;
    logic        fw_fire;
    logic        fw_arm;

    // command decode
    wire take      = i_cmd_valid & i_prog_mode;
    wire is_wr_low = take & (i_cmd_op == LFCS_OP_WR_FUSE_LOW);
    wire is_wr_hi  = take & (i_cmd_op == LFCS_OP_WR_FUSE_HIGH);
    wire is_wr_lk  = take & (i_cmd_op == LFCS_OP_WR_LOCK);
    wire is_erase  = take & (i_cmd_op == LFCS_OP_CHIP_ERASE);
    wire is_mem_wr = take & (i_cmd_op == LFCS_OP_MEM_WRITE);
    wire is_mem_rd = take & (i_cmd_op == LFCS_OP_MEM_VERIFY);
    wire is_read   = take & ((i_cmd_op == LFCS_OP_RD_CONFIG) | (i_cmd_op == LFCS_OP_RD_SIGNATURE) |
                             (i_cmd_op == LFCS_OP_RD_CALIB));

    lfcs_lock_decode u_decode (
        .i_lock        (lock_q),
        .o_mode        (mode),
        .o_fuse_locked (fuse_locked)
    );

    // refusals: fuse writes under any lock, memory access per mode
    wire fuse_refuse = (is_wr_low | is_wr_hi) & fuse_locked;
    wire wr_refuse   = is_mem_wr & (mode != LFCS_MODE_OPEN);
    wire rd_refuse   = is_mem_rd & (mode == LFCS_MODE_FULL_LOCK);
    wire refuse      = fuse_refuse | wr_refuse | rd_refuse;

    // serial mode cannot touch the serial enable fuse
    wire [7:0] low_wdata = i_prog_serial ? {nv_low_q[FL_SERIAL_BIT], i_cmd_data[6:0]}
                                         : i_cmd_data;

    // read answers; signature and calibration are never lock gated
    wire [7:0] sig_byte = (i_cmd_addr == SIG_ADDR_0) ? SIG_BYTE_0 :
                          (i_cmd_addr == SIG_ADDR_1) ? SIG_BYTE_1 :
                          (i_cmd_addr == SIG_ADDR_2) ? SIG_BYTE_2 : READ_BLANK;
    wire [7:0] cal_byte = (i_cmd_addr == CAL_ADDR_FAST) ? CAL_FAST :
                          (i_cmd_addr == CAL_ADDR_SLOW) ? CAL_SLOW : READ_BLANK;
    wire [7:0] cfg_byte = lfcs_sel_config({8'h00, i_cmd_addr}, nv_low_q, lock_q, nv_high_q);
    wire [7:0] rd_byte  = (i_cmd_op == LFCS_OP_RD_SIGNATURE) ? sig_byte :
                          (i_cmd_op == LFCS_OP_RD_CALIB) ? cal_byte : cfg_byte;

    // nonvolatile store; only a power-on reset restores the blank defaults
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            if (i_power_on) begin
                lock_q    <= LOCK_RESET;
                nv_low_q  <= FL_RESET;
                nv_high_q <= FH_RESET;
            end
        end else begin
            if (is_wr_lk)
                lock_q <= lock_q & i_cmd_data[1:0];
            else if (is_erase)
                lock_q <= LOCK_RESET;
            if (is_wr_low & ~fuse_locked)
                nv_low_q <= low_wdata;
            if (is_wr_hi & ~fuse_locked)
                nv_high_q <= i_cmd_data;
        end
    end

    // programmer answers, one cycle after the command is taken
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_ans_valid        <= 1'b0;
            o_ans_data         <= 8'h00;
            o_cmd_refused      <= 1'b0;
            o_mem_write_grant  <= 1'b0;
            o_mem_verify_grant <= 1'b0;
            o_flash_erase      <= 1'b0;
            o_eeprom_erase     <= 1'b0;
        end else begin
            o_ans_valid        <= is_read;
            o_ans_data         <= is_read ? rd_byte : 8'h00;
            o_cmd_refused      <= refuse;
            o_mem_write_grant  <= is_mem_wr & ~wr_refuse;
            o_mem_verify_grant <= is_mem_rd & ~rd_refuse;
            o_flash_erase      <= is_erase;
            o_eeprom_erase     <= is_erase & nv_low_q[FL_EE_KEEP_BIT];
        end
    end

    // working fuse copy follows the store only outside programming mode;
    // the first edge after reset captures it, so power-up latching is free
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            prog_mode_q        <= 1'b0;
            o_config_low_byte  <= FL_RESET;
            o_config_high_byte <= FH_RESET;
        end else begin
            prog_mode_q <= i_prog_mode;
            if (!prog_mode_q) begin
                o_config_low_byte  <= nv_low_q;
                o_config_high_byte <= nv_high_q;
            end
        end
    end

    // decoded controls; preserve bypasses the latch and tracks the store
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_protect_mode         <= LFCS_MODE_OPEN;
            o_debug_link_en        <= 1'b0;
            o_debug_pm_read_en     <= 1'b0;
            o_eeprom_preserve      <= 1'b0;
            o_watchdog_forced_on   <= 1'b0;
            o_watchdog_irq_allowed <= 1'b1;
        end else begin
            o_protect_mode         <= mode;
            o_debug_link_en        <= ~o_config_high_byte[FH_DEBUG_BIT] &
                                      (mode == LFCS_MODE_OPEN);
            o_debug_pm_read_en     <= ~o_config_high_byte[FH_DEBUG_BIT];
            o_eeprom_preserve      <= ~nv_low_q[FL_EE_KEEP_BIT];
            o_watchdog_forced_on   <= ~o_config_low_byte[FL_WDT_ON_BIT];
            o_watchdog_irq_allowed <= o_config_low_byte[FL_WDT_ON_BIT];
        end
    end

    // firmware read path: both enables written together open the window
    assign fw_arm = i_fw_ctrl_we & i_fw_read_config_bits_enable & i_fw_self_program_enable;

    lfcs_read_window #(
        .WINDOW (FW_WINDOW_CYCLES)
    ) u_window (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .i_arm   (fw_arm),
        .i_load  (i_fw_load),
        .o_fire  (fw_fire),
        .o_open  ()
    );

    // a load outside the window is a normal program fetch, not ours
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_fw_valid <= 1'b0;
            o_fw_data  <= 8'h00;
        end else begin
            o_fw_valid <= fw_fire;
            o_fw_data  <= fw_fire ? lfcs_sel_config(i_fw_ptr, nv_low_q, lock_q, nv_high_q)
                                  : 8'h00;
        end
    end

    // calibration register: reset loads the fast byte, firmware may override;
    // the slow byte reaches it only through a firmware write
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_oscillator_calibration_register <= CAL_FAST;
        end else if (i_oscillator_calibration_register_we) begin
            o_oscillator_calibration_register <= i_oscillator_calibration_register_wdata;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    lock_pad_ones_a: assert property (fw_fire && i_fw_ptr == PTR_LOCK |=> o_fw_data[7:2] == LOCK_PAD)
        else $error("lock byte upper bits not one");
    lock_only_erase_a: assert property (lock_q != $past(lock_q) && (lock_q & ~$past(lock_q)) != 2'h0
                                        |-> $past(is_erase))
        else $error("lock bit cleared without chip erase");
    mode_open_a: assert property (lock_q == LOCK_RESET |=> o_protect_mode == LFCS_MODE_OPEN)
        else $error("open lock bits not reported open");
    write_block_a: assert property (is_mem_wr && lock_q != LOCK_RESET
                                    |=> o_cmd_refused && !o_mem_write_grant)
        else $error("memory write allowed under lock");
    verify_block_a: assert property (is_mem_rd && !lock_q[LOCK_TWO_BIT]
                                     |=> o_cmd_refused && !o_mem_verify_grant)
        else $error("verify allowed in full lock");
    fuse_lock_a: assert property (is_wr_hi && !lock_q[LOCK_ONE_BIT]
                                  |=> $stable(nv_high_q) && o_cmd_refused)
        else $error("fuse changed while locked");
    serial_fuse_a: assert property (is_wr_low && i_prog_serial
                                    |=> nv_low_q[FL_SERIAL_BIT] == $past(nv_low_q[FL_SERIAL_BIT]))
        else $error("serial enable fuse changed in serial mode");
    erase_keeps_a: assert property (is_erase |=> $stable(nv_low_q) && $stable(nv_high_q))
        else $error("chip erase altered fuses");
    eeprom_erase_a: assert property (is_erase |=> o_eeprom_erase == $past(nv_low_q[FL_EE_KEEP_BIT]))
        else $error("eeprom erase does not follow preserve fuse");
    latch_hold_a: assert property (prog_mode_q && i_prog_mode
                                   |=> $stable(o_config_low_byte) && $stable(o_config_high_byte))
        else $error("latched fuses moved in programming mode");
    oscillator_calibration_register_reset_a: assert property (disable iff (1'b0) !i_rst_b |=> o_oscillator_calibration_register == CAL_FAST)
        else $error("calibration not loaded by reset");
    fw_read_a: assert property (fw_fire && i_fw_ptr == PTR_FUSE_HIGH
                                |=> o_fw_valid && o_fw_data == $past(nv_high_q))
        else $error("firmware fuse read wrong");
    debug_read_a: assert property (!o_config_high_byte[FH_DEBUG_BIT] |=> o_debug_pm_read_en)
        else $error("debug read lost with fuse programmed");

    cover_sig_locked_c: cover property (take && i_cmd_op == LFCS_OP_RD_SIGNATURE && fuse_locked ##1 o_ans_valid);
    cover_erase_c:      cover property (is_erase ##1 o_flash_erase);
    cover_fw_read_c:    cover property (fw_arm ##[1:3] fw_fire);
endmodule : lfcs_top
`default_nettype wire

// ---- test/lfcs_programmer_model.sv ----
// programmer model: drives programming mode and single-byte commands into the store
`timescale 1ns/1ps
`default_nettype none
module lfcs_programmer_model
    import lfcs_pkg::*;
(
    // clock
    input  wire logic                i_clock,
    // programmer pins toward the store
    output var logic                 o_prog_mode,
    output var logic                 o_prog_serial,
    output var logic                 o_cmd_valid,
    output var lfcs_pkg::lfcs_op_t   o_cmd_op,
    output var logic [7:0]           o_cmd_addr,
    output var logic [7:0]           o_cmd_data
);
    logic rst_dis_q;

    // idle at time zero; the command strobe only ever lasts one cycle
    initial begin
        rst_dis_q     = 1'b0;
        o_prog_mode   = 1'b0;
        o_prog_serial = 1'b1;
        o_cmd_valid   = 1'b0;
        o_cmd_op      = LFCS_OP_NOP;
        o_cmd_addr    = 8'h00;
        o_cmd_data    = 8'h00;
    end

    // once reset pin is given up, serial access is gone for good
    task automatic mode_set(input logic on, input logic serial);
        @(posedge i_clock);
        o_prog_mode   <= on;
        o_prog_serial <= serial & ~rst_dis_q;
    endtask : mode_set

    // one command per strobe; released address and data lines show the inverse, not the old value
    task automatic issue(input lfcs_op_t op, input logic [7:0] addr, input logic [7:0] data);
        @(posedge i_clock);
        o_cmd_valid <= 1'b1;
        o_cmd_op    <= op;
        o_cmd_addr  <= addr;
        o_cmd_data  <= data;
        if (op == LFCS_OP_WR_FUSE_HIGH && !data[FH_RST_DIS_BIT])
            rst_dis_q = 1'b1;
        @(posedge i_clock);
        o_cmd_valid <= 1'b0;
        o_cmd_op    <= LFCS_OP_NOP;
        o_cmd_addr  <= ~addr;
        o_cmd_data  <= ~data;
    endtask : issue
endmodule : lfcs_programmer_model
`default_nettype wire

// ---- test/test_lfcs_top.sv ----
// self-checking bench for the lock and fuse store
`timescale 1ns/1ps
`default_nettype none
module test_lfcs_top;
    import lfcs_pkg::*;
    localparam logic [7:0] SIG_T [3] = '{8'hA5, 8'hC3, 8'h10}; // arbitrary identity values
    localparam logic [7:0] CAL_F = 8'h47;
    localparam logic [7:0] CAL_S = 8'h39;
    localparam logic [1:0] PAT [3] = '{2'b10, 2'b01, 2'b00};
    // answer flags: answer, refused, write grant, verify grant, flash erase, eeprom erase
    localparam logic [5:0] F_A = 6'h20, F_R = 6'h10, F_W = 6'h08, F_V = 6'h04, F_E = 6'h02;
    logic i_clock, rst_b, power_on, prog_mode, prog_serial, cmd_valid, ans_valid, refused;
    logic wgrant, vgrant, ferase, eerase, fw_we, fw_rd, fw_sp, fw_load, cal_we, fw_valid;
    logic dbg_link, dbg_read, ee_keep, wdt_on, wdt_irq, taken_q;
    logic [7:0] cmd_addr, cmd_data, ans_data, cal_wdata, fw_data, oscillator_calibration_register, cfg_low, cfg_high, hi;
    logic [15:0] fw_ptr;
    lfcs_op_t cmd_op;
    lfcs_mode_t mode;
    logic [13:0] cmd_q[$];
    logic [7:0] fw_q[$];
    int miscompares, checks, cycles, p;

    lfcs_top #(.SIG_BYTE_0(SIG_T[0]), .SIG_BYTE_1(SIG_T[1]), .SIG_BYTE_2(SIG_T[2]), .CAL_FAST(CAL_F),
        .CAL_SLOW(CAL_S)) lfcs_top_inst (.i_clock(i_clock), .i_rst_b(rst_b), .i_power_on(power_on),
        .i_prog_mode(prog_mode), .i_prog_serial(prog_serial), .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op),
        .i_cmd_addr(cmd_addr), .i_cmd_data(cmd_data), .o_ans_valid(ans_valid), .o_ans_data(ans_data),
        .o_cmd_refused(refused), .o_mem_write_grant(wgrant), .o_mem_verify_grant(vgrant),
        .o_flash_erase(ferase), .o_eeprom_erase(eerase), .i_fw_ctrl_we(fw_we),
        .i_fw_read_config_bits_enable(fw_rd), .i_fw_self_program_enable(fw_sp), .i_fw_load(fw_load),
        .i_fw_ptr(fw_ptr), .i_oscillator_calibration_register_we(cal_we), .i_oscillator_calibration_register_wdata(cal_wdata), .o_fw_valid(fw_valid),
        .o_fw_data(fw_data), .o_oscillator_calibration_register(oscillator_calibration_register), .o_config_low_byte(cfg_low),
        .o_config_high_byte(cfg_high), .o_protect_mode(mode), .o_debug_link_en(dbg_link),
        .o_debug_pm_read_en(dbg_read), .o_eeprom_preserve(ee_keep), .o_watchdog_forced_on(wdt_on),
        .o_watchdog_irq_allowed(wdt_irq));
    lfcs_programmer_model lfcs_programmer_model_inst (.i_clock(i_clock), .o_prog_mode(prog_mode),
        .o_prog_serial(prog_serial), .o_cmd_valid(cmd_valid), .o_cmd_op(cmd_op), .o_cmd_addr(cmd_addr),
        .o_cmd_data(cmd_data));

    // clock and hang guard; the whole run needs well under two thousand cycles
    initial i_clock = 1'b0;
    always #2.5 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 4000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic conclude();
        if (miscompares == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    // watcher: every taken command owes exactly one noted answer, idle cycles owe none
    always @(posedge i_clock) begin
        if (rst_b && taken_q && cmd_q.size() > 0) begin
            check("cmd data", ans_data, cmd_q[0][7:0]);
            check("cmd flags", 8'({ans_valid, refused, wgrant, vgrant, ferase, eerase}), 8'(cmd_q.pop_front() >> 8));
        end else if (rst_b)
            check("idle flags", 8'({ans_valid, refused, wgrant, vgrant, ferase, eerase}), 8'h00);
        if (rst_b && fw_valid !== 1'b0)
            check("fw data", fw_data, (fw_q.size() > 0) ? fw_q.pop_front() : 8'hXX);
        taken_q <= cmd_valid & prog_mode;
    end

    task automatic pcmd(input lfcs_op_t op, input logic [7:0] a, input logic [7:0] d, input logic [5:0] f,
                        input logic [7:0] x);
        cmd_q.push_back({f, x});
        lfcs_programmer_model_inst.issue(op, a, d);
    endtask : pcmd

    // arm the read window, then load d cycles after the arming edge
    task automatic fw_read(input logic [15:0] ptr, input int d, input logic hit, input logic [7:0] x);
        if (hit)
            fw_q.push_back(x);
        @(posedge i_clock);
        {fw_we, fw_rd, fw_sp} <= 3'h7;
        @(posedge i_clock);
        {fw_we, fw_rd, fw_sp} <= 3'h0;
        repeat (d - 1) @(posedge i_clock);
        fw_load <= 1'b1;
        fw_ptr  <= ptr;
        @(posedge i_clock);
        fw_load <= 1'b0;
        fw_ptr  <= ~ptr;
        repeat (3) @(posedge i_clock);
    endtask : fw_read

    // main sequence
    initial begin
        {miscompares, checks, cycles, taken_q} = '0;
        {rst_b, power_on, fw_we, fw_rd, fw_sp, fw_load, cal_we} = 7'h20;
        {fw_ptr, cal_wdata} = '0;
        void'($urandom(32'h357E0F73));
        hi = (8'($urandom()) & 8'hF6) | 8'h01;
        repeat (20) @(posedge i_clock);
        rst_b    <= 1'b1;
        power_on <= 1'b0;
        repeat (3) @(posedge i_clock);
        check("low", cfg_low, FL_RESET);
        check("high", cfg_high, FH_RESET);
        check("status", {3'h0, wdt_on, wdt_irq, ee_keep, dbg_link, dbg_read}, 8'h08);
        check("mode", 8'(mode), 8'(LFCS_MODE_OPEN));
        lfcs_programmer_model_inst.mode_set(1'b1, 1'b1);
        for (p = 0; p < 3; p++)
            pcmd(LFCS_OP_RD_SIGNATURE, 8'(p), 8'h00, F_A, SIG_T[p]);
        pcmd(LFCS_OP_RD_CALIB, CAL_ADDR_FAST, 8'h00, F_A, CAL_F);
        pcmd(LFCS_OP_RD_CALIB, CAL_ADDR_SLOW, 8'h00, F_A, CAL_S);
        pcmd(LFCS_OP_RD_CONFIG, 8'h01, 8'h00, F_A, 8'hFF);
        // fuses go in before any lock bit
        pcmd(LFCS_OP_WR_FUSE_HIGH, 8'h00, hi, 6'h00, 8'h00);
        pcmd(LFCS_OP_RD_CONFIG, 8'h03, 8'h00, F_A, hi);
        pcmd(LFCS_OP_WR_FUSE_LOW, 8'h00, 8'h9F, 6'h00, 8'h00);
        pcmd(LFCS_OP_RD_CONFIG, 8'h00, 8'h00, F_A, 8'h1F);
        check("keep now", ee_keep, 8'h01);
        check("high held", cfg_high, FH_RESET);
        pcmd(LFCS_OP_MEM_WRITE, 8'h00, 8'h00, F_W, 8'h00);
        pcmd(LFCS_OP_MEM_VERIFY, 8'h00, 8'h00, F_V, 8'h00);
        pcmd(LFCS_OP_CHIP_ERASE, 8'h00, 8'h00, F_E, 8'h00);
        lfcs_programmer_model_inst.mode_set(1'b0, 1'b1);
        repeat (4) @(posedge i_clock);
        check("high late", cfg_high, hi);
        check("low late", cfg_low, 8'h1F);
        check("status", {3'h0, wdt_on, wdt_irq, ee_keep, dbg_link, dbg_read}, 8'h17);
        fw_read(PTR_LOCK, 1, 1'b1, 8'hFF);
        fw_read(PTR_FUSE_LOW, 3, 1'b1, 8'h1F);
        fw_read(PTR_FUSE_HIGH, 2, 1'b1, hi);
        fw_read(PTR_LOCK, 4, 1'b0, 8'h00);
        fw_read(16'h0002, 2, 1'b1, READ_BLANK);
        // each programmed lock pattern, high-voltage mode, erased again after each
        lfcs_programmer_model_inst.mode_set(1'b1, 1'b0);
        for (p = 0; p < 3; p++) begin
            pcmd(LFCS_OP_WR_LOCK, 8'h00, {6'h3F, PAT[p]}, 6'h00, 8'h00);
            pcmd(LFCS_OP_WR_LOCK, 8'h00, 8'hFF, 6'h00, 8'h00);
            pcmd(LFCS_OP_RD_CONFIG, 8'h01, 8'h00, F_A, {LOCK_PAD, PAT[p]});
            pcmd(LFCS_OP_MEM_WRITE, 8'h00, 8'h00, F_R, 8'h00);
            pcmd(LFCS_OP_MEM_VERIFY, 8'h00, 8'h00, PAT[p][1] ? F_V : F_R, 8'h00);
            pcmd(LFCS_OP_WR_FUSE_HIGH, 8'h00, 8'hFF, F_R, 8'h00);
            pcmd(LFCS_OP_WR_FUSE_LOW, 8'h00, 8'hFF, F_R, 8'h00);
            pcmd(LFCS_OP_RD_SIGNATURE, 8'h02, 8'h00, F_A, SIG_T[2]);
            check("mode", 8'(mode), 8'(PAT[p][1] ? LFCS_MODE_WRITE_LOCK : LFCS_MODE_FULL_LOCK));
            check("debug", {6'h0, dbg_link, dbg_read}, 8'h01);
            pcmd(LFCS_OP_CHIP_ERASE, 8'h00, 8'h00, F_E, 8'h00);
            pcmd(LFCS_OP_RD_CONFIG, 8'h03, 8'h00, F_A, hi);
        end
        // drop the preserve fuse so an erase must also clear eeprom
        pcmd(LFCS_OP_WR_FUSE_LOW, 8'h00, 8'hDF, 6'h00, 8'h00);
        pcmd(LFCS_OP_RD_CONFIG, 8'h00, 8'h00, F_A, 8'hDF);
        pcmd(LFCS_OP_CHIP_ERASE, 8'h00, 8'h00, F_E | 6'h01, 8'h00);
        lfcs_programmer_model_inst.mode_set(1'b0, 1'b0);
        @(posedge i_clock);
        cal_we    <= 1'b1;
        cal_wdata <= CAL_S;
        @(posedge i_clock);
        cal_we    <= 1'b0;
        cal_wdata <= ~CAL_S;
        @(posedge i_clock);
        check("cal fw", oscillator_calibration_register, CAL_S);
        rst_b <= 1'b0;
        repeat (3) @(posedge i_clock);
        rst_b <= 1'b1;
        repeat (3) @(posedge i_clock);
        check("cal reset", oscillator_calibration_register, CAL_F);
        check("high kept", cfg_high, hi);
        repeat (3) @(posedge i_clock);
        conclude();
    end
endmodule : test_lfcs_top
`default_nettype wire
